//--- include/fscb_pkg.sv
// Package: opcodes, bit positions, defaults and carriers of the status bank
// Assumes a clock of 250 MHz and an upstream byte decoder of the serial link
package fscb_pkg;

    // Instruction codes
    localparam logic [7:0] OP_WREN     = 8'h06;
    localparam logic [7:0] OP_WRDI     = 8'h04;
    localparam logic [7:0] OP_VWREN    = 8'h50;
    localparam logic [7:0] OP_WRSR1    = 8'h01;
    localparam logic [7:0] OP_WRSR2    = 8'h31;
    localparam logic [7:0] OP_WRSR3    = 8'h11;
    localparam logic [7:0] OP_SUSPEND  = 8'h75;
    localparam logic [7:0] OP_RESUME   = 8'h7a;
    localparam logic [7:0] OP_QUAD_ON  = 8'h38;
    localparam logic [7:0] OP_QUAD_OFF = 8'hff;
    localparam logic [7:0] OP_ADDR4_ON = 8'hb7;
    localparam logic [7:0] OP_ADDR4_OFF= 8'he9;
    localparam logic [7:0] OP_OTP_A    = 8'haa;
    localparam logic [7:0] OP_OTP_B    = 8'h55;

    // Bit positions within the first status byte (S7..S0)
    localparam int SR1_BUSY   = 0;
    localparam int SR1_LATCH  = 1;
    localparam int SR1_BP     = 2;
    localparam int SR1_TOPBOT = 6;
    localparam int SR1_PROT   = 7;
    // Second status byte (S15..S8)
    localparam int SR2_LOCK   = 0;
    localparam int SR2_QUAD   = 1;
    localparam int SR2_LB     = 3;
    localparam int SR2_COMPL  = 6;
    localparam int SR2_SUSP   = 7;
    // Third status byte (S23..S16)
    localparam int SR3_CURW   = 0;
    localparam int SR3_PUPW   = 1;
    localparam int SR3_SCHEME = 2;
    localparam int SR3_DRV    = 5;
    localparam int SR3_HRST   = 7;

    // Read selects
    localparam logic [1:0] SEL_SR1 = 2'h0;
    localparam logic [1:0] SEL_SR2 = 2'h1;
    localparam logic [1:0] SEL_SR3 = 2'h2;

    // Reset values
    localparam logic [1:0] DRV_RESET = 2'h3;
    localparam logic [7:0] RSVD_READ = 8'h00;

    // Internal status write time
    localparam int CLOCK_PERIOD_NS = 4;
    localparam int WRITE_TIME_NS   = 64;
    localparam logic [4:0] WRITE_CYCLES =
        5'((WRITE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);

    typedef struct packed {
        logic       valid;
        logic [7:0] code;
        logic [7:0] data;
    } fscb_instr_t;

    typedef struct packed {
        logic       protBit;
        logic       otpLock;
        logic [3:0] bp;
        logic       topBottom;
        logic       complBit;
        logic       quadEn;
        logic [2:0] lb;
        logic       pupWidth;
        logic       scheme;
        logic [1:0] drv;
        logic       holdRst;
    } fscb_nv_t;

    typedef enum {PFX_IDLE, PFX_GOT_A, PFX_ARMED} fscb_pfx_t;

endpackage

//--- logic/fscb_write_timer.sv
// Write cycle timer: busy for a fixed count after a start pulse
// Assumes start never arrives while busy
`timescale 1ns/10ps
`default_nettype none
module fscb_write_timer
    import fscb_pkg::*;
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic sys_rst,
    // Control
    input  wire logic start,
    output var  logic busy,
    output var  logic done
);

    logic [4:0] count_q;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            count_q <= 5'h00;
            done    <= 1'b0;
        end
        else
        begin
            done <= (count_q == 5'h01);
            if (start)
                count_q <= WRITE_CYCLES;
            else if (count_q != 5'h00)
                count_q <= count_q - 5'h01;
        end
    end

    assign busy = (count_q != 5'h00);

endmodule
`default_nettype wire

//--- logic/fscb_status_bank.sv
// Status and configuration bits of a serial flash, with write protection
// Assumes decoded instructions as one-cycle strobes; sys_rst is power-on
`timescale 1ns/10ps
`default_nettype none
module fscb_status_bank
    import fscb_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // Instruction strobe
    input  wire fscb_instr_t instr,
    output var  logic        instrReady,
    input  wire logic        devReset,
    input  wire logic        programDone,
    // Pins
    input  wire logic        writeProtectPinN,
    // Status read
    input  wire logic [1:0]  readSel,
    output var  logic [7:0]  readData,
    // Non-volatile image
    input  wire fscb_nv_t    nvImageIn,
    output var  fscb_nv_t    nvImageOut,
    output var  logic        nvCommit,
    // Configuration outputs
    output var  logic        busy,
    output var  logic        quadDataLines,
    output var  logic        writeProtectPinActive,
    output var  logic        pausePinActive,
    output var  logic        resetPinActive,
    output var  logic        fourWireCommandMode,
    output var  logic        addr4Byte,
    output var  logic        protectSchemeSelect,
    output var  logic [1:0]  outputDriveStrength,
    output var  logic [2:0]  securityLocked,
    output var  logic [5:0]  arrayProtectBits,
    output var  logic        lockAllBlocks,
    output var  logic        suspendFlag
);

    fscb_nv_t   nv_q;
    fscb_pfx_t  pfx_q;
    logic       latch_q;
    logic       volEn_q;
    logic       nvPath_q;
    logic       lockDown_q;
    logic       suspend_q;
    logic       fourWire_q;
    logic       curWidth_q;
    logic       lockAll_q;
    logic [7:0] readData_q;
    logic       take;
    logic       isWrite;
    logic       pinLocked;
    logic       accept;
    logic       done;
    logic [7:0] sr1;
    logic [7:0] sr2;
    logic [7:0] sr3;

    fscb_write_timer u_timer (
        .clock   (clock),
        .sys_rst (sys_rst),
        .start   (accept),
        .busy    (busy),
        .done    (done)
    );

    // Only suspend is taken while a write cycle runs
    assign instrReady = !busy || (instr.code == OP_SUSPEND);
    assign take       = instr.valid && instrReady;
    assign isWrite    = take && (instr.code == OP_WRSR1 ||
                        instr.code == OP_WRSR2 || instr.code == OP_WRSR3);
    // Pin counts only while it is not a quad data line
    assign pinLocked  = nv_q.protBit && !nv_q.quadEn
                        && !writeProtectPinN;
    // Lock and latch gating of status writes
    assign accept     = isWrite && (latch_q || volEn_q)
                        && !lockDown_q
                        && !nv_q.otpLock && !pinLocked;

    // Write enable latch and volatile enable
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            latch_q <= 1'b0;
            volEn_q <= 1'b0;
        end
        else if (done || programDone || (take && instr.code == OP_WRDI))
        begin
            latch_q <= 1'b0;
            volEn_q <= 1'b0;
        end
        else if (take && instr.code == OP_WREN)
            latch_q <= 1'b1;
        else if (take && instr.code == OP_VWREN)
            volEn_q <= 1'b1;
    end

    // Prefix sequence for permanent protection
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            pfx_q <= PFX_IDLE;
        else if (take)
        begin
            case (pfx_q)
                PFX_IDLE:  pfx_q <= (instr.code == OP_OTP_A) ? PFX_GOT_A
                                                             : PFX_IDLE;
                PFX_GOT_A: pfx_q <= (instr.code == OP_OTP_B) ? PFX_ARMED
                                                             : PFX_IDLE;
                PFX_ARMED: pfx_q <= PFX_IDLE;
                default:   pfx_q <= PFX_IDLE;
            endcase
        end
    end

    // Status bits held in the non-volatile image
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            nv_q <= nvImageIn;
        else if (accept)
        begin
            case (instr.code)
                OP_WRSR1:
                begin
                    nv_q.protBit   <= instr.data[SR1_PROT];
                    nv_q.topBottom <= instr.data[SR1_TOPBOT];
                    nv_q.bp        <= instr.data[SR1_BP +: 4];
                end
                OP_WRSR2:
                begin
                    nv_q.quadEn   <= instr.data[SR2_QUAD]
                                     || fourWire_q;
                    nv_q.lb       <= nv_q.lb | instr.data[SR2_LB +: 3];
                    nv_q.complBit <= instr.data[SR2_COMPL];
                    if (pfx_q == PFX_ARMED && instr.data[SR2_LOCK])
                        nv_q.otpLock <= 1'b1;
                end
                OP_WRSR3:
                begin
                    if (latch_q)
                        nv_q.pupWidth <= instr.data[SR3_PUPW];
                    nv_q.scheme  <= instr.data[SR3_SCHEME];
                    nv_q.drv     <= instr.data[SR3_DRV +: 2];
                    nv_q.holdRst <= instr.data[SR3_HRST];
                end
                default: nv_q <= nv_q;
            endcase
        end
    end

    // Lock-down bit, lost on power-on
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            lockDown_q <= 1'b0;
        else if (accept && instr.code == OP_WRSR2)
            lockDown_q <= instr.data[SR2_LOCK];
    end

    // Commit the image after a non-volatile write cycle
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            nvPath_q <= 1'b0;
            nvCommit <= 1'b0;
        end
        else
        begin
            if (accept)
                nvPath_q <= latch_q;
            nvCommit <= done && nvPath_q;
        end
    end

    // Suspend flag
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            suspend_q <= 1'b0;
        else if (take && instr.code == OP_SUSPEND)
            suspend_q <= 1'b1;
        else if (take && instr.code == OP_RESUME)
            suspend_q <= 1'b0;
    end

    // Four-wire command mode
    always_ff @(posedge clock)
    begin
        if (sys_rst || devReset)
            fourWire_q <= 1'b0;
        else if (take && instr.code == OP_QUAD_ON && nv_q.quadEn)
            fourWire_q <= 1'b1;
        else if (take && instr.code == OP_QUAD_OFF)
            fourWire_q <= 1'b0;
    end

    // Current address width, seeded from the power-up bit
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            curWidth_q <= nvImageIn.pupWidth;
        else if (devReset)
            curWidth_q <= nv_q.pupWidth;
        else if (take && instr.code == OP_ADDR4_ON)
            curWidth_q <= 1'b1;
        else if (take && instr.code == OP_ADDR4_OFF)
            curWidth_q <= 1'b0;
    end

    // Block lock set request after power-on or reset
    always_ff @(posedge clock)
    begin
        lockAll_q <= sys_rst || devReset;
    end

    // Status byte assembly, reserved bits read zero
    always_comb
    begin
        sr1 = {nv_q.protBit, nv_q.topBottom, nv_q.bp, latch_q, busy};
        sr2 = {suspend_q, nv_q.complBit, nv_q.lb, RSVD_READ[0], nv_q.quadEn,
               lockDown_q};
        sr3 = {nv_q.holdRst, nv_q.drv, RSVD_READ[1:0], nv_q.scheme,
               nv_q.pupWidth, curWidth_q};
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            readData_q <= 8'h00;
        else
        begin
            case (readSel)
                SEL_SR1: readData_q <= sr1;
                SEL_SR2: readData_q <= sr2;
                SEL_SR3: readData_q <= sr3;
                default: readData_q <= RSVD_READ;
            endcase
        end
    end

    // Outputs
    assign readData              = readData_q;
    assign nvImageOut            = nv_q;
    assign quadDataLines         = nv_q.quadEn;
    assign writeProtectPinActive = !nv_q.quadEn;
    assign pausePinActive        = !nv_q.quadEn && !nv_q.holdRst;
    assign resetPinActive        = !nv_q.quadEn && nv_q.holdRst;
    assign fourWireCommandMode   = fourWire_q;
    assign addr4Byte             = curWidth_q;
    assign protectSchemeSelect   = nv_q.scheme;
    assign outputDriveStrength   = nv_q.drv;
    assign securityLocked        = nv_q.lb;
    assign arrayProtectBits      = {nv_q.complBit, nv_q.topBottom,
                                    nv_q.bp};
    assign lockAllBlocks         = lockAll_q;
    assign suspendFlag           = suspend_q;

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence s_armed_otp;
        pfx_q == PFX_ARMED && accept && instr.code == OP_WRSR2
            && instr.data[SR2_LOCK];
    endsequence

    sequence s_write_cycle;
        busy [*8] ##[1:12] !busy;
    endsequence

    a_latch_set: assert property (take && instr.code == OP_WREN && !done
        && !programDone |=> latch_q) else $error("latch not set");
    a_pin_refuse: assert property (isWrite && pinLocked && !lockDown_q
        |=> !busy && $stable(nv_q)) else $error("pin lock ignored");
    a_soft_accept: assert property (isWrite && !lockDown_q
        && !nv_q.protBit && !nv_q.otpLock && latch_q |-> accept)
        else $error("software write refused");
    a_lockdown_hold: assert property (lockDown_q |-> !accept)
        else $error("lock-down write accepted");
    a_otp_set: assert property (s_armed_otp |=> nv_q.otpLock
        ##1 (nv_q.otpLock && !accept)) else $error("otp not set");
    a_write_time: assert property (accept |=> s_write_cycle)
        else $error("write cycle length wrong");
    a_latch_clear: assert property (done |=> !latch_q)
        else $error("latch not cleared");
    a_suspend_flag: assert property (take && instr.code == OP_SUSPEND
        |=> suspend_q) else $error("suspend flag not set");
    a_lock_sticky: assert property (nv_q.lb != 3'h0
        |=> (nv_q.lb & $past(nv_q.lb)) == $past(nv_q.lb))
        else $error("security lock cleared");
    a_quad_entry: assert property (take && instr.code == OP_QUAD_ON
        && !nv_q.quadEn && !fourWire_q |=> !fourWire_q)
        else $error("four-wire without quad");
    a_quad_hold: assert property (fourWire_q |-> nv_q.quadEn)
        else $error("quad enable dropped");
    a_width_reload: assert property (devReset
        |=> curWidth_q == $past(nv_q.pupWidth))
        else $error("address width not reloaded");
    a_lock_all: assert property ($fell(sys_rst) |-> lockAllBlocks)
        else $error("block locks not set");
    a_pause_pin: assert property (nv_q.quadEn |-> !pausePinActive
        && !resetPinActive) else $error("pin function with quad");

endmodule
`default_nettype wire

//--- verification/fscb_host_model.sv
// Host controller model: hands decoded instructions to the status bank
// Assumes instrReady settles one step after each rising clock edge
`timescale 1ns/10ps
`default_nettype none
module fscb_host_model
    import fscb_pkg::*;
(
    // Clock
    input  wire logic        clock,
    // Instruction handshake
    output var  fscb_instr_t instr,
    input  wire logic        instrReady
);
    initial
    begin
        instr = '0;
    end

    // Holds the request until taken, then shows the inverse
    task send(input logic [7:0] c, input logic [7:0] d, output logic ok);
        int         k;
        logic [7:0] m;
        m = d;
        if (c == OP_WRSR2) m[2] = 1'b0;
        if (c == OP_WRSR3) m[4:3] = 2'b00;
        k = 0;
        @(posedge clock);
        #1;
        instr = '{valid: 1'b1, code: c, data: m};
        while (instrReady !== 1'b1 && k < 40)
        begin
            @(posedge clock);
            #1;
            k++;
        end
        ok = (k < 40);
        @(posedge clock);
        #1;
        instr = '{valid: 1'b0, code: ~c, data: ~m};
    endtask
endmodule
`default_nettype wire

//--- verification/flash_status_config_bits_test.sv
// Testbench of the status bank: one task per scenario
// Assumes the package and the host model are compiled first
`timescale 1ns/10ps
`default_nettype none
module flash_status_config_bits_test
    import fscb_pkg::*;
;
    // Clock, reset and pins
    logic        clock, sys_rst, devReset, programDone;
    logic        writeProtectPinN, instrReady, nvCommit, busy;
    logic [1:0]  readSel, outputDriveStrength;
    logic [7:0]  readData, v;
    fscb_instr_t instr;
    fscb_nv_t    nvImageOut;
    fscb_nv_t    nvStore = '{drv: DRV_RESET, default: '0};
    logic [5:0]  arrayProtectBits;
    // Configuration outputs
    logic        quadDataLines, writeProtectPinActive, pausePinActive;
    logic        resetPinActive, fourWireCommandMode, addr4Byte;
    logic        protectSchemeSelect, lockAllBlocks, suspendFlag;
    logic [2:0]  securityLocked;
    int          error_cnt, comparisons, n;

    fscb_status_bank DUT (
        .clock(clock), .sys_rst(sys_rst), .instr(instr),
        .instrReady(instrReady), .devReset(devReset),
        .programDone(programDone), .writeProtectPinN(writeProtectPinN),
        .readSel(readSel), .readData(readData), .nvImageIn(nvStore),
        .nvImageOut(nvImageOut), .nvCommit(nvCommit), .busy(busy),
        .quadDataLines(quadDataLines),
        .writeProtectPinActive(writeProtectPinActive),
        .pausePinActive(pausePinActive), .resetPinActive(resetPinActive),
        .fourWireCommandMode(fourWireCommandMode), .addr4Byte(addr4Byte),
        .protectSchemeSelect(protectSchemeSelect),
        .outputDriveStrength(outputDriveStrength),
        .securityLocked(securityLocked),
        .arrayProtectBits(arrayProtectBits),
        .lockAllBlocks(lockAllBlocks), .suspendFlag(suspendFlag));

    fscb_host_model HOST (.clock(clock), .instr(instr),
        .instrReady(instrReady));

    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // Non-volatile store of the bank
    always @(posedge clock)
    begin
        if (nvCommit === 1'b1) nvStore <= nvImageOut;
    end

    task report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task fail();
        error_cnt++;
        $display("mismatch at %0t: wait ran out", $time);
        report_and_stop();
    endtask

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task send(input logic [7:0] c, input logic [7:0] d);
        logic ok;
        HOST.send(c, d, ok);
        if (ok !== 1'b1) fail();
    endtask

    // Counts busy cycles into n
    task idle();
        n = 0;
        while (busy === 1'b1 && n < 40)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        if (n == 40) fail();
    endtask

    task wr(input logic [7:0] op, input logic [7:0] d);
        send(OP_WREN, 8'h00);
        send(op, d);
        idle();
    endtask

    task rd(input logic [1:0] sel);
        readSel = sel;
        repeat (2) @(posedge clock);
        #1;
        v = readData;
    endtask

    task power_cycle();
        sys_rst = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        chk(8'(lockAllBlocks), 8'h01);
    endtask

    task t_reset();
        rd(SEL_SR2);
        chk(v, 8'h00);
        rd(SEL_SR3);
        chk(v, 8'h60);
        chk(8'(addr4Byte), 8'h00);
        chk(8'({writeProtectPinActive, pausePinActive}), 8'h03);
        rd(2'h3);
        chk(v, RSVD_READ);
        $display("test reset done");
    endtask

    task t_soft();
        writeProtectPinN = 1'b0;
        send(OP_WRSR2, 8'h02);
        chk(8'(busy), 8'h00);
        // Pins are driven, not tied, so quad enable may be set
        wr(OP_WRSR2, 8'h02);
        chk(8'(n), 8'(WRITE_CYCLES));
        rd(SEL_SR2);
        chk(v, 8'h02);
        chk(8'({quadDataLines, pausePinActive}), 8'h02);
        rd(SEL_SR1);
        chk(v, 8'h00);
        send(OP_WREN, 8'h00);
        rd(SEL_SR1);
        chk(v, 8'h02);
        programDone = 1'b1;
        @(posedge clock);
        #1;
        programDone = 1'b0;
        rd(SEL_SR1);
        chk(v, 8'h00);
        send(OP_WREN, 8'h00);
        send(OP_WRDI, 8'h00);
        rd(SEL_SR1);
        chk(v, 8'h00);
        writeProtectPinN = 1'b1;
        $display("test soft done");
    endtask

    task t_quad();
        wr(OP_WRSR2, 8'h00);
        send(OP_QUAD_ON, 8'h00);
        chk(8'(fourWireCommandMode), 8'h00);
        wr(OP_WRSR2, 8'h02);
        send(OP_QUAD_ON, 8'h00);
        chk(8'(fourWireCommandMode), 8'h01);
        wr(OP_WRSR2, 8'h00);
        rd(SEL_SR2);
        chk(v, 8'h02);
        send(OP_QUAD_OFF, 8'h00);
        wr(OP_WRSR2, 8'h00);
        $display("test quad done");
    endtask

    task t_pin();
        wr(OP_WRSR1, 8'hfc);
        chk(8'(arrayProtectBits), 8'h1f);
        writeProtectPinN = 1'b0;
        wr(OP_WRSR1, 8'h00);
        chk(8'(n), 8'h00);
        rd(SEL_SR1);
        chk(v, 8'hfe);
        writeProtectPinN = 1'b1;
        wr(OP_WRSR1, 8'h00);
        chk(8'(n), 8'(WRITE_CYCLES));
        $display("test pin done");
    endtask

    task t_lock();
        wr(OP_WRSR2, 8'h01);
        wr(OP_WRSR2, 8'h00);
        chk(8'(n), 8'h00);
        power_cycle();
        rd(SEL_SR2);
        chk(v, 8'h00);
        send(OP_WREN, 8'h00);
        send(OP_WRSR2, 8'h00);
        send(OP_SUSPEND, 8'h00);
        chk(8'(suspendFlag), 8'h01);
        idle();
        rd(SEL_SR2);
        chk(v, 8'h80);
        send(OP_RESUME, 8'h00);
        chk(8'(suspendFlag), 8'h00);
        $display("test lock and suspend done");
    endtask

    task t_cfg();
        wr(OP_WRSR2, 8'h08);
        chk(8'(securityLocked), 8'h01);
        wr(OP_WRSR2, 8'h20);
        rd(SEL_SR2);
        chk(v, 8'h28);
        for (int k = 0; k < 4; k++)
        begin
            wr(OP_WRSR3, 8'(k << 5));
            chk(8'(outputDriveStrength), 8'(k));
        end
        wr(OP_WRSR3, 8'he4);
        chk(8'({resetPinActive, protectSchemeSelect}), 8'h03);
        send(OP_VWREN, 8'h00);
        send(OP_WRSR3, 8'he6);
        idle();
        rd(SEL_SR3);
        chk(v, 8'he4);
        wr(OP_WRSR3, 8'he6);
        chk(8'(addr4Byte), 8'h00);
        devReset = 1'b1;
        @(posedge clock);
        #1;
        devReset = 1'b0;
        chk(8'({addr4Byte, lockAllBlocks}), 8'h03);
        send(OP_ADDR4_OFF, 8'h00);
        chk(8'(addr4Byte), 8'h00);
        send(OP_ADDR4_ON, 8'h00);
        chk(8'(addr4Byte), 8'h01);
        rd(SEL_SR3);
        chk(v, 8'he7);
        wr(OP_WRSR2, 8'h2a);
        chk(8'(resetPinActive), 8'h00);
        $display("test config done");
    endtask

    task t_otp();
        send(OP_WREN, 8'h00);
        send(OP_OTP_A, 8'h00);
        send(OP_OTP_B, 8'h00);
        send(OP_WRSR2, 8'h29);
        idle();
        // Let the commit pulse reach the store before power drops
        repeat (2) @(posedge clock);
        #1;
        power_cycle();
        chk(8'({nvStore.otpLock, addr4Byte}), 8'h03);
        wr(OP_WRSR2, 8'h28);
        chk(8'(n), 8'h00);
        $display("test permanent lock done");
    endtask

    initial
    begin
        error_cnt = 0;
        comparisons = 0;
        {sys_rst, devReset, programDone, writeProtectPinN} = 4'h9;
        readSel = SEL_SR1;
        repeat (12) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        t_reset();
        t_soft();
        t_quad();
        t_pin();
        t_lock();
        t_cfg();
        t_otp();
        report_and_stop();
    end
endmodule
`default_nettype wire
